// *** hw/pci_bridge_core.sv ***
// Bridge core: decode, claim, write merging, speed setup, secondary arbiter
`timescale 1ns/1ps
`include "bridge_params.svh"
module pci_bridge_core (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic req_valid,
    output logic req_ready,
    input wire bridge_pkg::req_t req,
    output logic devsel_n,
    output logic cfg_rvalid,
    output logic [31:0] cfg_rdata,
    output logic fwd_valid,
    input wire logic fwd_ready,
    output bridge_pkg::fwd_t fwd,
    input wire logic fast_capable_strap,
    input wire logic primary_fast_enable,
    input wire logic secondary_fast_enable_in,
    output logic secondary_fast_enable_out,
    output logic secondary_fast_enable_oe,
    output logic [`NUM_SCLK-1:0] secondary_clock_out,
    input wire logic [`NUM_MASTERS-1:0] master_req_n,
    output logic [`NUM_MASTERS-1:0] master_gnt_n,
    input wire logic [`NUM_MASTERS-1:0] high_tier_mask,
    input wire logic bridge_req,
    output logic bridge_gnt,
    input wire logic ext_arb_enable,
    output logic ext_req_n,
    input wire logic ext_gnt_n
);
    // Reset release chain
    logic rst_meta; // First stage, read only by rst_sync
    logic rst_sync; // Active-low reset used by the design

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    // Pin synchroniser: strap, two enables, nine requests, external grant
    // No reset, so the divider choice sees live pins while reset holds
    logic [12:0] pin_meta; // First stage
    logic [12:0] pin_sync; // Second stage, safe to read

    always_ff @(posedge ref_clk) begin
        pin_meta <= {ext_gnt_n, master_req_n, secondary_fast_enable_in,
                     primary_fast_enable, fast_capable_strap};
        pin_sync <= pin_meta;
    end

    logic strap_s; // Fast strap
    logic pfe_s;   // Primary fast enable
    logic sfe_s;   // Secondary fast enable as seen on the wire
    logic [`NUM_MASTERS-1:0] mreq_n_s; // Master requests
    logic egnt_n_s; // External grant
    assign strap_s = pin_sync[0];
    assign pfe_s = pin_sync[1];
    assign sfe_s = pin_sync[2];
    assign mreq_n_s = pin_sync[11:3];
    assign egnt_n_s = pin_sync[12];

    // Commands the bridge may claim as target
    function automatic logic cmd_claimable(input logic [3:0] c);
        unique case (c)
            4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9: cmd_claimable = 1'b0;
            default: cmd_claimable = 1'b1;
        endcase
    endfunction

    // Round-robin pick of the first requester after the last winner
    function automatic logic [3:0] rr_pick(input logic [9:0] r, input logic [3:0] last);
        logic [3:0] idx;
        logic found;
        idx = last;
        found = 1'b0;
        rr_pick = last;
        for (int i = 0; i < `NUM_AGENTS; i++) begin
            idx = (idx == `BRIDGE_AGENT) ? 4'h0 : idx + 4'h1;
            if (!found && r[idx]) begin
                rr_pick = idx;
                found = 1'b1;
            end
        end
    endfunction

    // Address phase decode
    logic [7:0] diag;      // Diagnostic control register
    logic merge_open;      // A burst is open for merging
    logic merge_dir;       // Direction of the open burst
    logic [31:0] merge_next; // Address that would continue it
    logic take;            // Address phase accepted this cycle
    logic is_cfg;          // Configuration read or write
    logic self_cfg;        // Access to the bridge's own header
    logic fwd_cfg;         // Type 1 access to pass on
    logic spec_req;        // Type 1 special cycle request
    logic claim;           // Bridge claims the cycle
    logic is_wr;           // Memory write or write-and-invalidate
    logic merge_on;        // Merging enabled
    logic cont;            // Word continues the open burst
    logic buf_in_valid;    // Word enters the buffer
    bridge_pkg::fwd_t buf_in; // Word for the buffer

    assign take = req_valid && req_ready;
    assign merge_on = !diag[`DIAG_MERGE_OFF];
    assign is_cfg = (req.cmd == `CMD_CFG_RD) || (req.cmd == `CMD_CFG_WR);
    // Own header only from the primary side, type 0, function 0
    assign self_cfg = is_cfg && !req.dir && req.idsel &&
                      (req.addr[1:0] == `TYPE0) && (req.addr[10:8] == `FUNC_ZERO);
    assign fwd_cfg = is_cfg && (req.addr[1:0] == `TYPE1);
    assign spec_req = fwd_cfg && (req.cmd == `CMD_CFG_WR) &&
                      (req.addr[15:11] == `SPEC_DEV) && (req.addr[10:8] == `SPEC_FUNC);
    assign claim = cmd_claimable(req.cmd) && (!is_cfg || self_cfg || fwd_cfg);
    assign is_wr = (req.cmd == `CMD_MEM_WR) || (req.cmd == `CMD_MEM_WRI);
    // Continue only at the doubleword after the last one, same direction
    assign cont = is_wr && merge_on && merge_open && (merge_dir == req.dir) &&
                  (req.addr == merge_next);
    assign buf_in_valid = take && claim && !self_cfg;

    // Build the forwarded word
    always_comb begin
        buf_in.dir = req.dir;
        buf_in.addr = req.addr;
        buf_in.data = req.data;
        buf_in.cont = cont;
        buf_in.cmd = req.cmd;
        if (spec_req) begin
            // Message goes out as a special cycle
            buf_in.cmd = `CMD_SPECIAL;
        end else if (req.cmd == `CMD_MEM_WRI && (!req.line_ok || cont)) begin
            // Whole line not guaranteed, or word continues a burst: plain write
            buf_in.cmd = `CMD_MEM_WR;
        end
    end

    // Forwarding buffer between decode and the far side
    fwd_skid_buffer u_buf (
        .clk(ref_clk),
        .rst_n(rst_sync),
        .in_valid(buf_in_valid),
        .in_ready(req_ready),
        .in_data(buf_in),
        .out_valid(fwd_valid),
        .out_ready(fwd_ready),
        .out_data(fwd)
    );

    // Merge tracking
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            merge_open <= 1'b0;
            merge_dir <= 1'b0;
            merge_next <= 32'h0000_0000;
        end else if (!merge_on) begin
            merge_open <= 1'b0;
        end else if (buf_in_valid) begin
            // Writes open or extend a burst, anything else closes it
            merge_open <= is_wr;
            merge_dir <= req.dir;
            merge_next <= req.addr + `DW_STEP;
        end
    end

    // Medium decode: DEVSEL two clocks after the address phase
    logic claim_d1; // Claim seen one clock ago

    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            claim_d1 <= 1'b0;
            devsel_n <= 1'b1;
        end else begin
            claim_d1 <= take && claim;
            devsel_n <= !claim_d1;
        end
    end

    // Own configuration header: diagnostic and status reads
    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            diag <= `DIAG_RESET;
            cfg_rvalid <= 1'b0;
            cfg_rdata <= 32'h0000_0000;
        end else begin
            cfg_rvalid <= take && self_cfg && (req.cmd == `CMD_CFG_RD);
            if (take && self_cfg && req.cmd == `CMD_CFG_WR &&
                {req.addr[7:2], 2'b00} == `OFS_DIAG) begin
                diag <= req.data[7:0];
            end
            if (take && self_cfg) begin
                cfg_rdata <= 32'h0000_0000;
                unique case ({req.addr[7:2], 2'b00})
                    `OFS_DIAG: cfg_rdata[7:0] <= diag;
                    `OFS_PRI_STATUS, `OFS_SEC_STATUS: cfg_rdata[`STATUS_CAP66] <= strap_s;
                    default: cfg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Speed setup: pull secondary enable low, pick the divider
    logic div_mode; // 66 primary with 33 secondary

    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            secondary_fast_enable_out <= 1'b0;
            secondary_fast_enable_oe <= 1'b0;
        end else begin
            secondary_fast_enable_out <= 1'b0;
            // Slow primary forces a slow secondary
            secondary_fast_enable_oe <= strap_s && !pfe_s;
        end
    end

    // Divider choice is sampled only while reset holds
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_mode <= 1'b0;
        end else if (!rst_sync) begin
            div_mode <= strap_s && pfe_s && !sfe_s;
        end
    end

    // Secondary clocks: toggle each edge, or every second edge when divided
    logic sclk_phase; // Half-rate phase for the divided case

    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            sclk_phase <= 1'b0;
            secondary_clock_out <= '0;
        end else begin
            sclk_phase <= !sclk_phase;
            if (!div_mode || sclk_phase) begin
                secondary_clock_out <= ~secondary_clock_out;
            end
        end
    end

    // Secondary arbiter: two rotating tiers, bridge always high
    bridge_pkg::arb_state_t arb_state; // Park or busy
    logic [3:0] last_hi; // Last high-tier winner
    logic [3:0] last_lo; // Last low-tier winner
    logic [3:0] owner;   // Current owner
    logic [9:0] areq;    // All requests, bridge on top
    logic [9:0] hreq;    // High-tier requests
    logic [9:0] lreq;    // Low-tier requests

    assign areq = {bridge_req, ~mreq_n_s};
    assign hreq = areq & {1'b1, high_tier_mask};
    assign lreq = areq & ~{1'b1, high_tier_mask};

    always_ff @(posedge ref_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            arb_state <= bridge_pkg::ARB_PARK;
            master_gnt_n <= '1;
            bridge_gnt <= 1'b0;
            last_hi <= `BRIDGE_AGENT;
            last_lo <= `BRIDGE_AGENT;
            owner <= 4'h0;
            ext_req_n <= 1'b1;
        end else if (ext_arb_enable) begin
            // Bypassed: follow the external arbiter
            arb_state <= bridge_pkg::ARB_PARK;
            master_gnt_n <= '1;
            ext_req_n <= !bridge_req;
            bridge_gnt <= !egnt_n_s;
        end else begin
            ext_req_n <= 1'b1;
            unique case (arb_state)
                bridge_pkg::ARB_PARK: begin
                    // Drop a grant left over from the bypassed mode
                    bridge_gnt <= 1'b0;
                    if (hreq != 10'h000) begin
                        // High tier first
                        owner <= rr_pick(hreq, last_hi);
                        last_hi <= rr_pick(hreq, last_hi);
                        bridge_gnt <= rr_pick(hreq, last_hi) == `BRIDGE_AGENT;
                        for (int i = 0; i < `NUM_MASTERS; i++) begin
                            master_gnt_n[i] <= rr_pick(hreq, last_hi) != 4'(i);
                        end
                        arb_state <= bridge_pkg::ARB_BUSY;
                    end else if (lreq != 10'h000) begin
                        // Low tier when high tier idle
                        owner <= rr_pick(lreq, last_lo);
                        last_lo <= rr_pick(lreq, last_lo);
                        for (int i = 0; i < `NUM_MASTERS; i++) begin
                            master_gnt_n[i] <= rr_pick(lreq, last_lo) != 4'(i);
                        end
                        arb_state <= bridge_pkg::ARB_BUSY;
                    end
                end
                bridge_pkg::ARB_BUSY: begin
                    // Release once the owner drops its request
                    if (!areq[owner]) begin
                        master_gnt_n <= '1;
                        bridge_gnt <= 1'b0;
                        arb_state <= bridge_pkg::ARB_PARK;
                    end
                end
                default: begin
                    master_gnt_n <= '1;
                    bridge_gnt <= 1'b0;
                    arb_state <= bridge_pkg::ARB_PARK;
                end
            endcase
        end
    end

    // Checks on the logic above
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_sync);

    sequence claimed_phase;
        take && claim;
    endsequence

    chk_devsel_two_late: assert property (claimed_phase
        |=> (devsel_n || $past(take && claim, 2)) ##1 !devsel_n)
        else $error("devsel not two clocks after claim");
    chk_no_claim_ack: assert property (take && !cmd_claimable(req.cmd) |-> ##2 devsel_n)
        else $error("unclaimable command was claimed");
    chk_cfg_secondary: assert property (take && req.dir && is_cfg && req.addr[1:0] == `TYPE0
        |-> ##2 devsel_n)
        else $error("secondary reached own header");
    chk_mwi_demote: assert property (buf_in_valid && req.cmd == `CMD_MEM_WRI && !req.line_ok
        |-> buf_in.cmd == `CMD_MEM_WR)
        else $error("write-and-invalidate not demoted");
    chk_merge_off: assert property (buf_in_valid && buf_in.cont |-> !diag[`DIAG_MERGE_OFF]
        && $past(merge_on))
        else $error("merge while disabled");
    chk_merge_addr: assert property (buf_in_valid && buf_in.cont
        |-> req.addr == $past(merge_next) || $past(buf_in_valid))
        else $error("merge at non-sequential address");
    chk_merge_close: assert property (!merge_on |=> !merge_open)
        else $error("merge left open after disable");
    chk_spec_origin: assert property (buf_in_valid && spec_req
        |-> buf_in.cmd == `CMD_SPECIAL ##1 fwd_valid)
        else $error("special cycle not originated");
    chk_fe_open_drain: assert property ($past(rst_sync) |-> !secondary_fast_enable_out &&
        (secondary_fast_enable_oe == $past(strap_s && !pfe_s)))
        else $error("secondary fast enable misdriven");
    chk_div_stable: assert property (rst_sync && $past(rst_sync) |-> $stable(div_mode))
        else $error("clock rate changed outside reset");
    chk_sclk_rate: assert property ($past(rst_sync, 4) |-> (div_mode ?
        secondary_clock_out[0] != $past(secondary_clock_out[0], 2) :
        secondary_clock_out[0] != $past(secondary_clock_out[0])))
        else $error("secondary clock rate wrong");
    chk_grant_one: assert property ($onehot0({bridge_gnt && !ext_arb_enable, ~master_gnt_n}))
        else $error("more than one grant");
    chk_ext_bypass: assert property (ext_arb_enable |=> master_gnt_n == '1)
        else $error("internal grant while bypassed");
endmodule

// *** inc/bridge_params.svh ***
// Constants of the bridge core: command codes, offsets, field positions
// Function
// - Decode address-phase command lines as standard codes
// - Never claim interrupt ack, special or reserved
// - Originate special cycle from type 1 request
// - Assert DEVSEL two clocks after address phase
// - Forward write-and-invalidate as write without full line
// - Merge consecutive memory writes into one burst
// - Merge only at next sequential doubleword address
// - Merging on after reset, diagnostic bit 0 disables
// - Fast strap sets both status capable bits
// - Support 66/66, 66/33, 33/33 speed pairings only
// - Strap high, primary slow: pull secondary enable low
// - Divide clock by two for 66/33 operation
// - Sample both fast enables to pick divide
// - Drive ten secondary clock outputs
// - Configuration header reachable from primary only
// - Arbiter serves nine masters with request/grant pairs
// - Two rotating tiers, bridge in high tier
// - Internal arbiter may be bypassed for external
// - Delayed and posted buffer sizes per direction; the core has one two-entry buffer shared by both directions
// - Both interfaces 32 bits, up to 66 MHz
// - Secondary fast enable is open drain only
`ifndef BRIDGE_PARAMS_SVH
`define BRIDGE_PARAMS_SVH
// Command codes on the command/byte-enable lines
`define CMD_INT_ACK 4'h0
`define CMD_SPECIAL 4'h1
`define CMD_MEM_RD 4'h6
`define CMD_MEM_WR 4'h7
`define CMD_CFG_RD 4'ha
`define CMD_CFG_WR 4'hb
`define CMD_MEM_WRI 4'hf
// Configuration offsets
`define OFS_DIAG 8'hf0
`define OFS_PRI_STATUS 8'h04
`define OFS_SEC_STATUS 8'h1c
`define DIAG_RESET 8'h00
`define DIAG_MERGE_OFF 0
`define STATUS_CAP66 21
// Type 1 special cycle request fields
`define SPEC_DEV 5'h1f
`define SPEC_FUNC 3'h7
`define FUNC_ZERO 3'h0
`define TYPE0 2'b00
`define TYPE1 2'b01
// Arbiter and clock counts
`define NUM_MASTERS 9
`define NUM_AGENTS 10
`define BRIDGE_AGENT 4'h9
`define NUM_SCLK 10
`define DW_STEP 32'h0000_0004
// Buffer sizes in doublewords, per direction
`define DLY_RSP_DW 32
`define DLY_RSP_COUNT 3
`define BOOT_CONFIGURATION_SOFTWARE_DW 64
`endif

// *** inc/bridge_pkg.sv ***
// Types shared by the bridge core and its forwarding buffer
package bridge_pkg;
    // One address phase with its first data word
    typedef struct packed {
        logic dir;         // 1 = from secondary side
        logic [3:0] cmd;   // Command code
        logic [31:0] addr; // Address phase value
        logic [31:0] data; // Data or special-cycle message
        logic idsel;       // Configuration select
        logic line_ok;     // Full cache line guaranteed
    } req_t;
    // One word queued for the far side
    typedef struct packed {
        logic dir;         // 1 = toward primary
        logic [3:0] cmd;   // Command to issue
        logic [31:0] addr; // Address
        logic [31:0] data; // Data
        logic cont;        // Continues the previous burst
    } fwd_t;
    // Arbiter states
    typedef enum logic [1:0] {
        ARB_PARK = 2'b01,
        ARB_BUSY = 2'b10
    } arb_state_t;
endpackage

// *** hw/fwd_skid_buffer.sv ***
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module fwd_skid_buffer (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire bridge_pkg::fwd_t in_data,
    output logic out_valid,
    input wire logic out_ready,
    output bridge_pkg::fwd_t out_data
);
    bridge_pkg::fwd_t skid; // Second entry, filled on stall
    logic skid_valid;       // Second entry occupied

    // Ready only while the second entry is free
    assign in_ready = ~skid_valid;

    // Head entry and overflow entry
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_valid <= 1'b0;
            out_data <= '0;
            skid_valid <= 1'b0;
            skid <= '0;
        end else if (out_ready || !out_valid) begin
            // Head drains or is empty
            if (skid_valid) begin
                out_data <= skid;
                out_valid <= 1'b1;
                skid_valid <= 1'b0;
            end else begin
                out_valid <= in_valid;
                if (in_valid) begin
                    out_data <= in_data;
                end
            end
        end else if (in_valid && !skid_valid) begin
            // Head stalled: park the word
            skid <= in_data;
            skid_valid <= 1'b1;
        end
    end
endmodule

// *** test/fwd_sink_model.sv ***
// Far-side model that takes forwarded words and can stall
`timescale 1ns/1ps
module fwd_sink_model (
    input wire logic ref_clk,
    input wire logic stall,
    input wire logic fwd_valid,
    output logic fwd_ready,
    input wire bridge_pkg::fwd_t fwd
);
    // Words taken, oldest first
    bridge_pkg::fwd_t got[$];
    initial fwd_ready = 1'b0;
    // Ready changes only just after an edge, so a stall is seen whole
    always @(posedge ref_clk) begin
        fwd_ready <= !stall;
    end
    // Capture a word at the edge where both sides agree
    always @(posedge ref_clk) begin
        if (fwd_valid === 1'b1 && fwd_ready) begin
            got.push_back(fwd);
        end
    end
endmodule

// *** test/pci_to_pci_bridge_core_tb_top.sv ***
// Testbench for the bridge core: claims, own header, merging, speed, arbiter
`timescale 1ns/1ps
module pci_to_pci_bridge_core_tb_top;
    logic ref_clk, nrst, req_valid, req_ready, devsel_n, cfg_rvalid, fwd_valid, fwd_ready;
    logic strap, pfe, sfe_pull, sfe_out, sfe_oe, bridge_req, bridge_gnt, ext_en, ext_req_n;
    logic ext_gnt_n, stall, ok;
    logic [31:0] cfg_rdata;
    logic [9:0] sclk;
    logic [8:0] mreq_n, mgnt_n, tier;
    bridge_pkg::req_t req;
    bridge_pkg::fwd_t fwd;
    int errors, cmp_count, n;
    realtime t0;
    wire sfe_wire = sfe_oe ? 1'b0 : sfe_pull; // Open-drain wire with pull
    pci_bridge_core i_dut (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .devsel_n(devsel_n), .cfg_rvalid(cfg_rvalid),
        .cfg_rdata(cfg_rdata), .fwd_valid(fwd_valid), .fwd_ready(fwd_ready), .fwd(fwd),
        .fast_capable_strap(strap), .primary_fast_enable(pfe),
        .secondary_fast_enable_in(sfe_wire), .secondary_fast_enable_out(sfe_out),
        .secondary_fast_enable_oe(sfe_oe), .secondary_clock_out(sclk),
        .master_req_n(mreq_n), .master_gnt_n(mgnt_n), .high_tier_mask(tier),
        .bridge_req(bridge_req), .bridge_gnt(bridge_gnt), .ext_arb_enable(ext_en),
        .ext_req_n(ext_req_n), .ext_gnt_n(ext_gnt_n));
    fwd_sink_model i_sink (.ref_clk(ref_clk), .stall(stall), .fwd_valid(fwd_valid),
        .fwd_ready(fwd_ready), .fwd(fwd));
    // Free-running 50 ns clock
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    // Report counts and verdict, then stop
    task finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Compare one value
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Hold reset low for a number of cycles, then wait out the release
    task do_reset(input int cyc);
        nrst <= 1'b0;
        repeat (cyc) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask
    // Offer one address phase until taken or eight edges pass
    task put(input bridge_pkg::req_t r, output logic taken);
        @(posedge ref_clk);
        req_valid <= 1'b1;
        req <= r;
        taken = 1'b0;
        for (int k = 0; k < 8 && !taken; k++) begin
            @(posedge ref_clk);
            taken = req_ready;
        end
        req_valid <= 1'b0;
    endtask
    // Send a request and check read answer and claim timing
    task issue(input bridge_pkg::req_t r, input logic claim, input logic rd,
               input logic [31:0] rdata);
        put(r, ok);
        chk("taken", ok, 1);
        #1;
        chk("cfg_rvalid", cfg_rvalid, rd);
        if (rd) chk("cfg_rdata", cfg_rdata, rdata);
        @(posedge ref_clk);
        #1;
        chk("devsel_n", devsel_n, !claim);
    endtask
    // Check one forwarded word
    task fx(input int i, input logic [3:0] c, input logic [31:0] a, input logic ct);
        chk("fwd cmd", i_sink.got[i].cmd, c);
        chk("fwd addr", i_sink.got[i].addr, a);
        chk("fwd cont", i_sink.got[i].cont, ct);
    endtask
    // Time between two rises of the secondary clock, in ns
    task sclk_period(input int exp);
        @(posedge sclk[0]);
        t0 = $realtime;
        @(posedge sclk[0]);
        chk("sclk period", 32'($rtoi($realtime - t0)), exp);
        chk("sclk equal", {22'h0, sclk}, sclk[0] ? 32'h3ff : 32'h0);
    endtask
    // Hang guard: far beyond the expected run length
    initial begin
        #2000000;
        errors++;
        finish_test;
    end
    // Main sequence
    initial begin
        errors = 0; cmp_count = 0; nrst = 0; req_valid = 0; req = '0; stall = 0;
        strap = 0; pfe = 0; sfe_pull = 0; mreq_n = 9'h1ff; tier = 9'h0;
        bridge_req = 0; ext_en = 0; ext_gnt_n = 1;
        do_reset(4);
        chk("idle", {devsel_n, fwd_valid, sfe_oe, bridge_gnt, ext_req_n, mgnt_n}, 32'h23ff);
        sclk_period(100);
        // Every command code from the primary side, config as type 0 function 0
        for (int c = 0; c < 16; c++) begin
            issue('{1'b0, 4'(c), 32'h0, 32'h0, 1'b1, 1'b1},
                  !(c inside {0, 1, 4, 5, 8, 9}), c == 10, 32'h0);
        end
        issue('{1'b1, 4'ha, 32'hf0, 32'h0, 1'b1, 1'b1}, 0, 0, 0);
        issue('{1'b0, 4'ha, 32'h1f0, 32'h0, 1'b1, 1'b1}, 0, 0, 0);
        repeat (4) @(posedge ref_clk);
        i_sink.got.delete();
        // Merging, a gap, both MWI forms and a special-cycle request
        issue('{1'b0, 4'h7, 32'h100, 32'h1, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b1, 4'h7, 32'h100, 32'h1, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b1, 4'h7, 32'h104, 32'h2, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b1, 4'h7, 32'h10c, 32'h3, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b0, 4'hf, 32'h200, 32'h4, 1'b0, 1'b0}, 1, 0, 0);
        issue('{1'b0, 4'hf, 32'h300, 32'h5, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b0, 4'hb, 32'hff01, 32'h55, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b0, 4'hb, 32'hf0, 32'h1, 1'b1, 1'b1}, 1, 0, 0);
        issue('{1'b0, 4'ha, 32'hf0, 32'h0, 1'b1, 1'b1}, 1, 1, 32'h1);
        issue('{1'b0, 4'h7, 32'h400, 32'h6, 1'b0, 1'b1}, 1, 0, 0);
        issue('{1'b0, 4'h7, 32'h404, 32'h7, 1'b0, 1'b1}, 1, 0, 0);
        repeat (6) @(posedge ref_clk);
        chk("fwd count", i_sink.got.size(), 9);
        fx(0, 4'h7, 32'h100, 0);
        fx(1, 4'h7, 32'h100, 0);
        fx(2, 4'h7, 32'h104, 1);
        fx(3, 4'h7, 32'h10c, 0);
        fx(4, 4'h7, 32'h200, 0);
        fx(5, 4'hf, 32'h300, 0);
        fx(6, 4'h1, 32'hff01, 0);
        chk("special msg", i_sink.got[6].data, 32'h55);
        fx(8, 4'h7, 32'h404, 0);
        // Stalled far side: fill until refused, then drain with nothing lost
        i_sink.got.delete();
        stall <= 1'b1;
        n = 0;
        ok = 1'b1;
        while (ok && n < 6) begin
            put('{1'b0, 4'h6, 32'(n * 16), 32'h0, 1'b0, 1'b1}, ok);
            if (ok) n++;
        end
        chk("refused when full", ok, 0);
        stall <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk("drained count", i_sink.got.size(), n);
        // Arbiter: high tier wins, then release drops the grant
        tier <= 9'h020;
        mreq_n <= 9'h1db;
        repeat (8) @(posedge ref_clk);
        chk("grant high tier", mgnt_n, 9'h1df);
        mreq_n <= 9'h1ff;
        repeat (8) @(posedge ref_clk);
        chk("grant release", mgnt_n, 9'h1ff);
        // External arbiter path
        ext_en <= 1'b1;
        bridge_req <= 1'b1;
        mreq_n <= 9'h1fe;
        ext_gnt_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        chk("ext path", {ext_req_n, bridge_gnt, mgnt_n}, 32'h3ff);
        ext_en <= 1'b0;
        bridge_req <= 1'b0;
        mreq_n <= 9'h1ff;
        ext_gnt_n <= 1'b1;
        // Strap high, primary slow: pull secondary enable low
        strap <= 1'b1;
        sfe_pull <= 1'b1;
        repeat (6) @(posedge ref_clk);
        chk("sfe pull low", {sfe_oe, sfe_out, sfe_wire}, 32'h4);
        issue('{1'b0, 4'ha, 32'h04, 32'h0, 1'b1, 1'b1}, 1, 1, 32'h200000);
        issue('{1'b0, 4'ha, 32'h1c, 32'h0, 1'b1, 1'b1}, 1, 1, 32'h200000);
        // Fast primary, slow secondary chosen in reset: divided clock
        @(posedge ref_clk);
        pfe <= 1'b1;
        sfe_pull <= 1'b0;
        do_reset(8);
        sclk_period(200);
        sfe_pull <= 1'b1;
        repeat (8) @(posedge ref_clk);
        sclk_period(200);
        finish_test;
    end
endmodule
